/* hdl/bmw_pkg.sv */
package bmw_pkg;

    // Decoded address width: 32-bit lower half plus the 12 writable upper bits
    localparam int unsigned ADDR_W = 44;
    // Register bus address width, enough for the status word at 0x100
    localparam int unsigned AXI_AW = 12;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_NP_BASE = 8'h20;
    localparam logic [7:0] IDX_NP_LIMIT = 8'h22;
    localparam logic [7:0] IDX_PF_BASE = 8'h24;
    localparam logic [7:0] IDX_PF_LIMIT = 8'h26;
    localparam logic [7:0] IDX_PF_BASE_HIGH = 8'h28;
    localparam logic [7:0] IDX_STATUS = 8'h40;

    localparam logic [AXI_AW-1:0] ADR_NP_BASE = {2'h0, IDX_NP_BASE, 2'h0};
    localparam logic [AXI_AW-1:0] ADR_NP_LIMIT = {2'h0, IDX_NP_LIMIT, 2'h0};
    localparam logic [AXI_AW-1:0] ADR_PF_BASE = {2'h0, IDX_PF_BASE, 2'h0};
    localparam logic [AXI_AW-1:0] ADR_PF_LIMIT = {2'h0, IDX_PF_LIMIT, 2'h0};
    localparam logic [AXI_AW-1:0] ADR_PF_BASE_HIGH = {2'h0, IDX_PF_BASE_HIGH, 2'h0};
    localparam logic [AXI_AW-1:0] ADR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // Window field layout inside the 16-bit registers
    localparam int unsigned FIELD_LSB = 4;
    localparam int unsigned FIELD_W = 12;
    // Writable width of the upper base extension
    localparam int unsigned HIGH_W = 12;
    // Address bits below the window granularity
    localparam int unsigned LOW_BITS = 20;
    localparam logic [LOW_BITS-1:0] LOW_ZERO = 20'h00000;
    localparam logic [LOW_BITS-1:0] LOW_ONES = 20'hFFFFF;
    // Read-only capability code in bits 3:0 of the prefetchable pair
    localparam logic [3:0] CAP_CODE = 4'h0;

    // Reset values
    localparam logic [FIELD_W-1:0] FIELD_RST = 12'h000;
    localparam logic [HIGH_W-1:0] HIGH_RST = 12'h000;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // Status word layout
    localparam int unsigned STS_NP_HIT = 0;
    localparam int unsigned STS_PF_HIT = 1;
    localparam int unsigned STS_FWD = 2;
    localparam int unsigned STS_SEEN = 3;
    localparam int unsigned STS_COUNT_LSB = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Memory cycle offered from the upstream hub link
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } bmw_cyc_type;

    // Registered forwarding decision
    typedef struct packed {
        logic valid;
        logic fwd;
        logic npHit;
        logic pfHit;
        logic [ADDR_W-1:0] addr;
    } bmw_res_type;

    typedef enum logic [0:0] {
        W_IDLE,
        W_RESP
    } bmw_wstate_type;

    // Whole state of the register bank
    typedef struct packed {
        logic [FIELD_W-1:0] npBase;
        logic [FIELD_W-1:0] npLimit;
        logic [FIELD_W-1:0] pfBase;
        logic [FIELD_W-1:0] pfLimit;
        logic [HIGH_W-1:0] pfBaseHigh;
        bmw_wstate_type wState;
        logic awHave;
        logic [AXI_AW-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } bmw_state_type;

endpackage : bmw_pkg

/* hdl/bmw_window_cmp.sv */
`timescale 1ns/1ns
// Inclusive range check of one address against a decoded window
module bmw_window_cmp #(
    parameter int unsigned AW = 44
) (
    input wire logic [AW-1:0] addr, // Incoming cycle address
    input wire logic [AW-1:0] bottom, // First byte of the window
    input wire logic [AW-1:0] top, // Last byte of the window
    output logic hit // Address inside the window
);

    // An inverted window (bottom above top) simply never hits
    assign hit = (addr >= bottom) && (addr <= top);

endmodule : bmw_window_cmp

/* hdl/bmw_fwd_stage.sv */
`timescale 1ns/1ns
// Registers the forwarding decision of each offered memory cycle
module bmw_fwd_stage (
    input wire logic mclk,
    input wire logic rst_n,
    input wire bmw_pkg::bmw_cyc_type cyc, // Offered cycle
    input wire logic npHit, // Cycle inside non-prefetchable window
    input wire logic pfHit, // Cycle inside prefetchable window
    output bmw_pkg::bmw_res_type res, // Decision, one cycle after the offer
    output logic [15:0] fwdCount // Forwarded cycles, wraps
);

    typedef struct packed {
        bmw_pkg::bmw_res_type res;
        logic [15:0] count;
    } bmw_fwd_state_type;

    bmw_fwd_state_type s_r; // Current state
    bmw_fwd_state_type s_nxt; // Next state

    // Decision follows every offer; the valid bit drops when none is offered
    always_comb begin
        s_nxt = s_r;
        s_nxt.res.valid = cyc.valid;
        s_nxt.res.npHit = cyc.valid && npHit;
        s_nxt.res.pfHit = cyc.valid && pfHit;
        s_nxt.res.fwd = cyc.valid && (npHit || pfHit);
        s_nxt.res.addr = cyc.addr;
        if (cyc.valid && (npHit || pfHit)) begin
            s_nxt.count = s_r.count + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign res = s_r.res;
    assign fwdCount = s_r.count;

endmodule : bmw_fwd_stage

/* hdl/bmw_window_decode.sv */
`timescale 1ns/1ns
module bmw_window_decode (
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite write address channel
    input wire logic [bmw_pkg::AXI_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address channel
    input wire logic [bmw_pkg::AXI_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Memory cycle offered by the upstream hub link, same clock
    input wire bmw_pkg::bmw_cyc_type hubCyc,
    // Forwarding decision toward the downstream bus
    output bmw_pkg::bmw_res_type fwdRes
);

    bmw_pkg::bmw_state_type s_r; // Current state
    bmw_pkg::bmw_state_type s_nxt; // Next state

    logic [bmw_pkg::ADDR_W-1:0] npBottom; // Decoded non-prefetchable bottom
    logic [bmw_pkg::ADDR_W-1:0] npTop; // Decoded non-prefetchable top
    logic [bmw_pkg::ADDR_W-1:0] pfBottom; // Decoded prefetchable bottom
    logic [bmw_pkg::ADDR_W-1:0] pfTop; // Decoded prefetchable top
    logic npHit; // Offered cycle hits non-prefetchable window
    logic pfHit; // Offered cycle hits prefetchable window
    logic [15:0] fwdCount; // Forwarded cycle count
    logic wrFire; // Both halves of a write present, response slot free
    logic rdFire; // Read address taken this cycle

    // Protection bits carry nothing for this bank
    logic unusedProt;
    assign unusedProt = ^{awprot, arprot};

    // Merge byte lanes 0 and 1 into a 16-bit register image
    function automatic logic [15:0] merge16(
        input logic [15:0] oldVal,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] val;
        val = oldVal;
        if (strb[0]) begin
            val[7:0] = data[7:0];
        end
        if (strb[1]) begin
            val[15:8] = data[15:8];
        end
        return val;
    endfunction : merge16

    // Lift a 12-bit window field into its register image
    function automatic logic [15:0] fieldImage(
        input logic [bmw_pkg::FIELD_W-1:0] field,
        input logic [3:0] lowBits
    );
        return {field, lowBits};
    endfunction : fieldImage

    // Window bounds. The low nibbles of the registers never enter here, so
    // reserved and capability bits cannot disturb the decode.
    always_comb begin
        npBottom = {{(bmw_pkg::ADDR_W - 32){1'b0}}, s_r.npBase, bmw_pkg::LOW_ZERO};
        npTop = {{(bmw_pkg::ADDR_W - 32){1'b0}}, s_r.npLimit, bmw_pkg::LOW_ONES};
        pfBottom = {s_r.pfBaseHigh, s_r.pfBase, bmw_pkg::LOW_ZERO};
        // No limit extension is kept, so the prefetchable top stays below 4 GB
        pfTop = {{bmw_pkg::HIGH_W{1'b0}}, s_r.pfLimit, bmw_pkg::LOW_ONES};
    end

    // Non-prefetchable window compare
    bmw_window_cmp #(
        .AW(bmw_pkg::ADDR_W)
    ) npCmp (
        .addr(hubCyc.addr),
        .bottom(npBottom),
        .top(npTop),
        .hit(npHit)
    );

    // Prefetchable window compare; meaningful once software has set the
    // base, since after reset both windows cover only the first 1 MB
    bmw_window_cmp #(
        .AW(bmw_pkg::ADDR_W)
    ) pfCmp (
        .addr(hubCyc.addr),
        .bottom(pfBottom),
        .top(pfTop),
        .hit(pfHit)
    );

    // Registered forwarding decision and counter
    bmw_fwd_stage fwdStage (
        .mclk(mclk),
        .rst_n(rst_n),
        .cyc(hubCyc),
        .npHit(npHit),
        .pfHit(pfHit),
        .res(fwdRes),
        .fwdCount(fwdCount)
    );

    // Handshake outputs straight from state
    assign awready = !s_r.awHave;
    assign wready = !s_r.wHave;
    assign bvalid = (s_r.wState == bmw_pkg::W_RESP);
    assign bresp = s_r.bResp;
    assign arready = !s_r.rValid;
    assign rvalid = s_r.rValid;
    assign rdata = s_r.rData;
    assign rresp = s_r.rResp;

    // A write commits only once no response is waiting, so a slow bready
    // holds both channels off instead of losing a response
    assign wrFire = s_r.awHave && s_r.wHave && (s_r.wState == bmw_pkg::W_IDLE);
    assign rdFire = arvalid && !s_r.rValid;

    // Next state of the bank and the bus slave
    always_comb begin
        logic [15:0] img;
        logic [31:0] rd;
        logic hitAddr;
        img = 16'h0000;
        rd = 32'h00000000;
        hitAddr = 1'b1;
        s_nxt = s_r;

        // Capture write address and data in either order
        if (awvalid && !s_r.awHave) begin
            s_nxt.awHave = 1'b1;
            s_nxt.awAddr = awaddr;
        end
        if (wvalid && !s_r.wHave) begin
            s_nxt.wHave = 1'b1;
            s_nxt.wData = wdata;
            s_nxt.wStrb = wstrb;
        end

        // Write commit: update the addressed field through the byte lanes
        if (wrFire) begin
            s_nxt.awHave = 1'b0;
            s_nxt.wHave = 1'b0;
            s_nxt.wState = bmw_pkg::W_RESP;
            s_nxt.bResp = bmw_pkg::RESP_OKAY;
            unique case (s_r.awAddr)
                bmw_pkg::ADR_NP_BASE: begin
                    // Bits 3:0 are reserved and discarded
                    img = merge16(fieldImage(s_r.npBase, 4'h0), s_r.wData, s_r.wStrb);
                    s_nxt.npBase = img[15:bmw_pkg::FIELD_LSB];
                end
                bmw_pkg::ADR_NP_LIMIT: begin
                    img = merge16(fieldImage(s_r.npLimit, 4'h0), s_r.wData, s_r.wStrb);
                    s_nxt.npLimit = img[15:bmw_pkg::FIELD_LSB];
                end
                bmw_pkg::ADR_PF_BASE: begin
                    // Capability nibble is read-only, written data ignored
                    img = merge16(fieldImage(s_r.pfBase, bmw_pkg::CAP_CODE), s_r.wData, s_r.wStrb);
                    s_nxt.pfBase = img[15:bmw_pkg::FIELD_LSB];
                end
                bmw_pkg::ADR_PF_LIMIT: begin
                    img = merge16(fieldImage(s_r.pfLimit, bmw_pkg::CAP_CODE), s_r.wData, s_r.wStrb);
                    s_nxt.pfLimit = img[15:bmw_pkg::FIELD_LSB];
                end
                bmw_pkg::ADR_PF_BASE_HIGH: begin
                    // Only the low twelve bits hold; bits 31:12 drop away
                    img = merge16({4'h0, s_r.pfBaseHigh}, s_r.wData, s_r.wStrb);
                    s_nxt.pfBaseHigh = img[bmw_pkg::HIGH_W-1:0];
                end
                bmw_pkg::ADR_STATUS: begin
                    // Status is read-only; a write is accepted and ignored
                end
                default: begin
                    // Unmapped address: nothing stored, error answered
                    s_nxt.bResp = bmw_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Response leaves once the master takes it
        if ((s_r.wState == bmw_pkg::W_RESP) && bready) begin
            s_nxt.wState = bmw_pkg::W_IDLE;
        end

        // Read: data is latched at address acceptance and held until taken
        if (rdFire) begin
            unique case (araddr)
                bmw_pkg::ADR_NP_BASE: begin
                    rd = {16'h0000, fieldImage(s_r.npBase, 4'h0)};
                end
                bmw_pkg::ADR_NP_LIMIT: begin
                    rd = {16'h0000, fieldImage(s_r.npLimit, 4'h0)};
                end
                bmw_pkg::ADR_PF_BASE: begin
                    rd = {16'h0000, fieldImage(s_r.pfBase, bmw_pkg::CAP_CODE)};
                end
                bmw_pkg::ADR_PF_LIMIT: begin
                    rd = {16'h0000, fieldImage(s_r.pfLimit, bmw_pkg::CAP_CODE)};
                end
                bmw_pkg::ADR_PF_BASE_HIGH: begin
                    // Reserved bits 31:12 read as zero
                    rd = {20'h00000, s_r.pfBaseHigh};
                end
                bmw_pkg::ADR_STATUS: begin
                    // Last decision and running count of forwarded cycles
                    rd[bmw_pkg::STS_NP_HIT] = fwdRes.npHit;
                    rd[bmw_pkg::STS_PF_HIT] = fwdRes.pfHit;
                    rd[bmw_pkg::STS_FWD] = fwdRes.fwd;
                    rd[bmw_pkg::STS_SEEN] = fwdRes.valid;
                    rd[bmw_pkg::STS_COUNT_LSB +: 16] = fwdCount;
                end
                default: begin
                    hitAddr = 1'b0;
                end
            endcase
            s_nxt.rValid = 1'b1;
            s_nxt.rData = rd;
            s_nxt.rResp = hitAddr ? bmw_pkg::RESP_OKAY : bmw_pkg::RESP_SLVERR;
        end else if (s_r.rValid && rready) begin
            s_nxt.rValid = 1'b0;
        end
    end

    // State register; every window field resets to zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.npBase <= bmw_pkg::FIELD_RST;
            s_r.npLimit <= bmw_pkg::FIELD_RST;
            s_r.pfBase <= bmw_pkg::FIELD_RST;
            s_r.pfLimit <= bmw_pkg::FIELD_RST;
            s_r.pfBaseHigh <= bmw_pkg::HIGH_RST;
            s_r.wState <= bmw_pkg::W_IDLE;
            s_r.awHave <= 1'b0;
            s_r.awAddr <= '0;
            s_r.wHave <= 1'b0;
            s_r.wData <= 32'h00000000;
            s_r.wStrb <= 4'h0;
            s_r.bResp <= bmw_pkg::RESP_OKAY;
            s_r.rValid <= 1'b0;
            s_r.rData <= 32'h00000000;
            s_r.rResp <= bmw_pkg::RESP_OKAY;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : bmw_window_decode

/* dv/bmw_properties.sv */
`timescale 1ns/1ns
// Watches the bank ports and shadows the window fields from committed bus writes
module bmw_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [bmw_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [bmw_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire bmw_pkg::bmw_cyc_type hubCyc,
    input wire bmw_pkg::bmw_res_type fwdRes
);
    logic awGot_r, wGot_r; // Halves of a write taken but not yet committed
    logic [11:0] aAdr_r; // Taken write address
    logic [31:0] wDat_r; // Taken write data
    logic [3:0] wStb_r; // Taken byte lanes
    logic [11:0] npB_r, npL_r, pfB_r, pfL_r, hi_r; // Shadow window fields

    // Lane-wise merge for the 16-bit windows, field sits in bits 15:4
    function automatic logic [11:0] fld16(input logic [11:0] o);
        fld16 = {wStb_r[1] ? wDat_r[15:8] : o[11:4], wStb_r[0] ? wDat_r[7:4] : o[3:0]};
    endfunction : fld16

    // Lane-wise merge for the upper extension, bits 11:0 only
    function automatic logic [11:0] fldHi(input logic [11:0] o);
        fldHi = {wStb_r[1] ? wDat_r[11:8] : o[11:8], wStb_r[0] ? wDat_r[7:0] : o[7:0]};
    endfunction : fldHi

    // Commit happens one edge after both halves are held, same as the bank
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awGot_r <= 1'b0;
            wGot_r <= 1'b0;
            {npB_r, npL_r, pfB_r, pfL_r, hi_r} <= '0;
        end else begin
            if (awvalid && awready) begin
                awGot_r <= 1'b1;
                aAdr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wGot_r <= 1'b1;
                wDat_r <= wdata;
                wStb_r <= wstrb;
            end
            if (awGot_r && wGot_r && !bvalid) begin
                awGot_r <= 1'b0;
                wGot_r <= 1'b0;
                case (aAdr_r)
                    bmw_pkg::ADR_NP_BASE: npB_r <= fld16(npB_r);
                    bmw_pkg::ADR_NP_LIMIT: npL_r <= fld16(npL_r);
                    bmw_pkg::ADR_PF_BASE: pfB_r <= fld16(pfB_r);
                    bmw_pkg::ADR_PF_LIMIT: pfL_r <= fld16(pfL_r);
                    bmw_pkg::ADR_PF_BASE_HIGH: hi_r <= fldHi(hi_r);
                    default: ;
                endcase
            end
        end
    end

    // Expected hits of the offered address against the shadow windows
    logic npExp, pfExp;
    assign npExp = hubCyc.addr[43:32] == 12'h000 && hubCyc.addr[31:0] >= {npB_r, 20'h00000}
        && hubCyc.addr[31:0] <= {npL_r, 20'hFFFFF};
    assign pfExp = hubCyc.addr >= {hi_r, pfB_r, 20'h00000} && hubCyc.addr <= {12'h000, pfL_r, 20'hFFFFF};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence offerS;
        hubCyc.valid;
    endsequence
    sequence readS(logic [11:0] a);
        arvalid && arready && araddr == a;
    endsequence

    fwd_or_a: assert property (fwdRes.valid |-> fwdRes.fwd == (fwdRes.npHit || fwdRes.pfHit))
        else $error("forward flag differs from window hits");
    offer_echo_a: assert property (offerS |=> fwdRes.valid && fwdRes.addr == $past(hubCyc.addr))
        else $error("decision missing one cycle after offer");
    np_decode_a: assert property (offerS |=> fwdRes.npHit == $past(npExp))
        else $error("non-prefetchable hit wrong");
    pf_decode_a: assert property (offerS |=> fwdRes.pfHit == $past(pfExp))
        else $error("prefetchable hit wrong");
    np_upper_a: assert property (fwdRes.npHit |-> fwdRes.addr[43:32] == 12'h000)
        else $error("non-prefetchable hit above 32 bits");
    np_base_read_a: assert property (readS(bmw_pkg::ADR_NP_BASE) |=> rdata == {16'h0000, npB_r, 4'h0})
        else $error("non-prefetchable base readback wrong");
    np_limit_read_a: assert property (readS(bmw_pkg::ADR_NP_LIMIT) |=> rdata == {16'h0000, npL_r, 4'h0})
        else $error("non-prefetchable limit readback wrong");
    pf_base_read_a: assert property (readS(bmw_pkg::ADR_PF_BASE) |=> rdata == {16'h0000, pfB_r, bmw_pkg::CAP_CODE})
        else $error("prefetchable base readback wrong");
    pf_limit_read_a: assert property (readS(bmw_pkg::ADR_PF_LIMIT) |=> rdata == {16'h0000, pfL_r, bmw_pkg::CAP_CODE})
        else $error("prefetchable limit readback wrong");
    high_read_a: assert property (readS(bmw_pkg::ADR_PF_BASE_HIGH) |=> rdata == {20'h00000, hi_r})
        else $error("upper extension readback wrong");
endmodule : bmw_properties

/* dv/bmw_hub_model.sv */
`timescale 1ns/1ns
// Upstream hub link side: offers one memory cycle at a time
module bmw_hub_model (
    input wire logic mclk,
    output bmw_pkg::bmw_cyc_type cyc
);
    // Link quiet until the first offer
    initial cyc = '0;

    // Valid for one clock; afterwards the address lines show the inverse so stale data is never trusted
    task automatic offer(input logic [bmw_pkg::ADDR_W-1:0] a);
        @(posedge mclk);
        cyc.valid <= 1'b1;
        cyc.addr <= a;
        @(posedge mclk);
        cyc.valid <= 1'b0;
        cyc.addr <= ~a;
    endtask : offer
endmodule : bmw_hub_model

/* dv/bmw_window_decode_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module bmw_window_decode_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    bmw_pkg::bmw_cyc_type hubCyc;
    bmw_pkg::bmw_res_type fwdRes;
    int err_total = 0;
    int checks = 0;
    int fwdCnt = 0; // Forwarded offers expected so far
    localparam logic [1:0] OK = bmw_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = bmw_pkg::RESP_SLVERR;

    always #5 mclk = ~mclk;

    bmw_window_decode dut (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hubCyc(hubCyc), .fwdRes(fwdRes));
    bmw_hub_model hub (.mclk(mclk), .cyc(hubCyc));

    // Verdict and end of run
    task automatic results;
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge mclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (bvalid !== 1'b1) begin
            err_total++;
            results();
        end
        `CHK(bresp, er)
    endtask : wr

    // Read with optional compare mask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge mclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (rvalid !== 1'b1) begin
            err_total++;
            results();
        end
        `CHK(rdata & m, ed & m)
        `CHK(rresp, er)
    endtask : rd

    // Offer one cycle and compare the decision one clock later
    task automatic probe(input logic [43:0] a, input logic np, input logic pf);
        hub.offer(a);
        #1;
        `CHK(fwdRes.valid, 1'b1)
        `CHK(fwdRes.addr, a)
        `CHK({fwdRes.npHit, fwdRes.pfHit, fwdRes.fwd}, {np, pf, np | pf})
        if (np | pf) fwdCnt++;
    endtask : probe

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values; capability code in the prefetchable pair
        rd(bmw_pkg::ADR_NP_BASE, 32'h0, OK);
        rd(bmw_pkg::ADR_NP_LIMIT, 32'h0, OK);
        rd(bmw_pkg::ADR_PF_BASE, {28'h0, bmw_pkg::CAP_CODE}, OK);
        rd(bmw_pkg::ADR_PF_LIMIT, {28'h0, bmw_pkg::CAP_CODE}, OK);
        rd(bmw_pkg::ADR_PF_BASE_HIGH, 32'h0, OK);
        probe(44'h000_0000_0000, 1'b1, 1'b1);
        probe(44'h000_0010_0000, 1'b0, 1'b0);
        // Non-prefetchable window; low nibble written but reserved
        wr(bmw_pkg::ADR_NP_BASE, 32'hFFFF_123F, OK);
        wr(bmw_pkg::ADR_NP_LIMIT, 32'h0000_125A, OK);
        rd(bmw_pkg::ADR_NP_BASE, 32'h0000_1230, OK);
        rd(bmw_pkg::ADR_NP_LIMIT, 32'h0000_1250, OK);
        probe(44'h000_1230_0000, 1'b1, 1'b0);
        probe(44'h000_122F_FFFF, 1'b0, 1'b0);
        probe(44'h000_125F_FFFF, 1'b1, 1'b0);
        probe(44'h000_1260_0000, 1'b0, 1'b0);
        probe(44'h001_1240_0000, 1'b0, 1'b0);
        // Software sets the prefetchable base before relying on it
        wr(bmw_pkg::ADR_PF_BASE, 32'h0000_800F, OK);
        wr(bmw_pkg::ADR_PF_LIMIT, 32'h0000_80FF, OK);
        rd(bmw_pkg::ADR_PF_BASE, {16'h0, 12'h800, bmw_pkg::CAP_CODE}, OK);
        rd(bmw_pkg::ADR_PF_LIMIT, {16'h0, 12'h80F, bmw_pkg::CAP_CODE}, OK);
        probe(44'h000_8000_0000, 1'b0, 1'b1);
        probe(44'h000_7FFF_FFFF, 1'b0, 1'b0);
        probe(44'h000_80FF_FFFF, 1'b0, 1'b1);
        probe(44'h000_8100_0000, 1'b0, 1'b0);
        // Upper extension: only 12 bits stick, and it raises the bottom
        wr(bmw_pkg::ADR_PF_BASE_HIGH, 32'hFFFF_FABC, OK);
        rd(bmw_pkg::ADR_PF_BASE_HIGH, 32'h0000_0ABC, OK);
        probe(44'h000_8000_0000, 1'b0, 1'b0);
        probe(44'hABC_8000_0000, 1'b0, 1'b0);
        wr(bmw_pkg::ADR_PF_BASE_HIGH, 32'h0, OK);
        probe(44'h000_8000_0000, 1'b0, 1'b1);
        // Unmapped place, ignored status write, forwarded count
        wr(12'h084, 32'h1234_5678, ERR);
        rd(12'h084, 32'h0, ERR);
        wr(bmw_pkg::ADR_STATUS, 32'hFFFF_FFFF, OK);
        // No offer stands now, so the last-decision bits must read idle
        rd(bmw_pkg::ADR_STATUS, {fwdCnt[15:0], 16'h0}, OK, 32'hFFFF_000F);
        results();
    end

    // Hang guard
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule : bmw_window_decode_tb

bind bmw_window_decode bmw_properties chk (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .hubCyc(hubCyc), .fwdRes(fwdRes));
